// *** src/ecs_pkg.sv ***
package ecs_pkg;
  // Phases of one machine cycle
  localparam logic [2:0] PH_FIRST = 3'h0;
  localparam logic [2:0] PH_RESTORE = 3'h1;
  localparam logic [2:0] PH_LATCH = 3'h2;
  localparam logic [2:0] PH_ARITH = 3'h3;
  localparam logic [2:0] PH_STORE = 3'h4;
  localparam logic [2:0] PH_LAST = 3'h7;
  // I/O function codes
  localparam logic [2:0] FN_DIAG = 3'h0;
  localparam logic [2:0] FN_WRITE = 3'h1;
  localparam logic [2:0] FN_READ = 3'h2;
  localparam logic [2:0] FN_SENSE_INT = 3'h3;
  localparam logic [2:0] FN_CONTROL = 3'h4;
  localparam logic [2:0] FN_INIT_WRITE = 3'h5;
  localparam logic [2:0] FN_INIT_READ = 3'h6;
  localparam logic [2:0] FN_SENSE_DEV = 3'h7;
  // Control word fields
  localparam int AREA_MSB = 4;
  localparam int AREA_LSB = 0;
  localparam int FUNC_MSB = 7;
  localparam int FUNC_LSB = 5;
  localparam int MOD_MSB = 15;
  localparam int MOD_LSB = 8;
  localparam int DIAG_BIT = 15;
  localparam int FMT_BIT = 5;
  localparam int IND_BIT = 8;
  localparam logic [15:0] ODD_BIT = 16'h0001;
  localparam logic [15:0] EVEN_MASK = 16'hfffe;
  localparam logic [4:0] DIAG_LEVEL = 5'h1f;
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_TWO = 4'h2;

  // Opcode classes
  typedef enum logic [3:0] {
    ecs_op_wait = 4'h0, ecs_op_shift = 4'h1, ecs_op_ldstat = 4'h2,
    ecs_op_branch = 4'h3, ecs_op_ldx_noreg = 4'h4, ecs_op_single = 4'h5,
    ecs_op_add = 4'h6, ecs_op_double = 4'h7, ecs_op_io = 4'h8,
    ecs_op_sub = 4'h9, ecs_op_store = 4'ha, ecs_op_cmp = 4'hb
  } ecs_op_t;

  // Sequencer states, Gray along the indirect path from idle to step three
  typedef enum logic [2:0] {
    ecs_idle = 3'b000, ecs_instr = 3'b001, ecs_indirect = 3'b011,
    ecs_step_one = 3'b010, ecs_step_two = 3'b110, ecs_step_three = 3'b111
  } ecs_state_t;
endpackage : ecs_pkg

// *** src/ecs_io_if.sv ***
`timescale 1ns/1ps
// Out-bus and in-bus between sequencer and I/O adapters
interface ecs_io_if (
  input wire logic clk,
  input wire logic rst
);
  logic [15:0] out_bus;
  logic out_ctrl;
  logic out_data;
  logic in_sample;
  logic [15:0] car_load;
  logic car_strobe;
  logic [15:0] in_bus;
  logic in_valid;

  modport seq (
    output out_bus, out_ctrl, out_data, in_sample, car_load, car_strobe,
    input in_bus, in_valid
  );
  modport adapter (
    input out_bus, out_ctrl, out_data, in_sample, car_load, car_strobe,
    output in_bus, in_valid
  );
endinterface : ecs_io_if

// *** src/ecs_seq.sv ***
`timescale 1ns/1ps
// Function
// - Indirect cycle fetches direct address into accumulator
// - No-execute opcodes end in instruction time
// - Step count chosen from opcode class
// - Return to idle when done
// - Phase zero reads storage at effective address
// - Accumulator stashed, restored in first step except for I/O
// - Shift counter decrements each step
// - Latch to operand at phase two, arithmetic flags at phase three
// - Phase four writes back, operates on accumulator
// - Last phase extends for add, subtract or double with shift count
// - Opcode gating advances steps, blocks functions
// - First I/O step puts control word out
// - Control and sense data in step two
// - Read/write: address step two, data three
// - Initialize loads channel address, then ends
// - Format flag picks one or two words
// - Software gives even effective address
// - Control word at odd address goes first
// - Adapter decodes area, modifier picks device
// - Three-bit function code decode
// - Sense ignores address, status into accumulator
// - Diagnostic mode set by modifier bit
// - Read/write move one word, direct control
module ecs_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire ecs_pkg::ecs_op_t op_class,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] eff_addr,
  input wire logic [3:0] shift_count,
  output logic busy,
  output logic done,
  output logic [15:0] acc,
  output logic [15:0] channel_address_register,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  output logic [2:0] phase,
  ecs_io_if.seq io
);
  import ecs_pkg::*;

  ecs_state_t state;
  ecs_op_t op;
  logic [15:0] latch;
  logic [15:0] operand;
  logic [15:0] stash;
  logic [3:0] sctr;
  logic [2:0] func;
  logic arith_ctl;
  logic indirect;
  logic extend;
  logic last_step;

  // Step count needed by the opcode class
  function automatic logic [1:0] steps_of(input ecs_op_t o);
    case (o)
      ecs_op_io, ecs_op_double: steps_of = 2'h2;
      ecs_op_single, ecs_op_add, ecs_op_sub, ecs_op_store,
      ecs_op_cmp: steps_of = 2'h1;
      default: steps_of = 2'h0;
    endcase
  endfunction : steps_of

  // True in any of the three execution steps
  function automatic logic is_step(input ecs_state_t s);
    is_step = s == ecs_step_one || s == ecs_step_two || s == ecs_step_three;
  endfunction : is_step

  // Sense functions take status instead of reading storage
  function automatic logic is_sense(input logic [2:0] f);
    is_sense = f == FN_SENSE_DEV || f == FN_SENSE_INT;
  endfunction : is_sense

  // ***************************************************
  // Phase and sequencing
  // ***************************************************
  // Phase-seven extension for add, subtract and double-word shift
  always_comb begin
    // Only execution steps stretch, so a step never starts at phase seven
    extend = is_step(state)
      && (((op == ecs_op_add || op == ecs_op_sub) && operand != 16'h0)
      || (op == ecs_op_double && sctr != 4'h0));
    last_step = (state == ecs_step_one && steps_of(op) == 2'h1)
      || (state == ecs_step_two && !(op == ecs_op_io
      && (func == FN_WRITE || func == FN_READ)))
      || state == ecs_step_three;
  end

  // Phase counter, held at last phase while extended
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= PH_FIRST;
    end else if (state == ecs_idle) begin
      phase <= PH_FIRST;
    end else if (!(phase == PH_LAST && extend)) begin
      phase <= phase + 3'h1;
    end
  end

  // Cycle-to-cycle advance gated by opcode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ecs_idle;
      op <= ecs_op_wait;
      indirect <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ecs_idle: begin
          if (start) begin
            state <= ecs_instr;
            op <= op_class;
            // Two-word form honours the indirect flag
            indirect <= instr_word[FMT_BIT] && instr_word[IND_BIT];
            busy <= 1'b1;
          end
        end
        ecs_instr, ecs_indirect: begin
          if (phase == PH_LAST) begin
            if (state == ecs_instr && indirect) begin
              state <= ecs_indirect;
            end else if (steps_of(op) == 2'h0) begin
              state <= ecs_idle;
              busy <= 1'b0;
              done <= 1'b1;
            end else begin
              state <= ecs_step_one;
            end
          end
        end
        default: begin
          if (phase == PH_LAST && !extend) begin
            if (last_step) begin
              state <= ecs_idle;
              busy <= 1'b0;
              done <= 1'b1;
            end else if (state == ecs_step_one) begin
              state <= ecs_step_two;
            end else begin
              state <= ecs_step_three;
            end
          end
        end
      endcase
    end
  end

  // ***************************************************
  // Datapath per phase
  // ***************************************************
  // Storage address and read strobe at phase zero, address held to write-back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_addr <= 16'h0;
      mem_rd <= 1'b0;
    end else begin
      mem_rd <= 1'b0;
      if (phase == PH_FIRST) begin
        if (state == ecs_indirect) begin
          mem_addr <= acc;
          mem_rd <= 1'b1;
        end else if (state == ecs_step_one && op == ecs_op_io) begin
          mem_addr <= (acc & EVEN_MASK) | ODD_BIT;
          mem_rd <= 1'b1;
        end else if (state == ecs_step_two && op == ecs_op_io) begin
          mem_addr <= acc & EVEN_MASK;
          mem_rd <= !is_sense(func);
        end else if (state == ecs_step_three) begin
          mem_addr <= acc;
          mem_rd <= func == FN_WRITE;
        end else if (state == ecs_step_one || state == ecs_step_two) begin
          // Step two takes the location after step one's, as acc is reused
          mem_addr <= (state == ecs_step_two) ? mem_addr + ODD_BIT
            : acc;
          mem_rd <= 1'b1;
        end
      end
    end
  end

  // Storage word latch, loaded after a read or on the adapter's answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch <= 16'h0;
    end else if (phase == PH_RESTORE && mem_rd) begin
      latch <= mem_rdata;
    end else if (io.in_valid && is_step(state)) begin
      latch <= io.in_bus;
    end
  end

  // Operation input and arithmetic control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      operand <= 16'h0;
      arith_ctl <= 1'b0;
    end else if (state == ecs_idle) begin
      arith_ctl <= 1'b0;
    end else begin
      if (phase == PH_LATCH) begin
        operand <= latch;
      end
      if (phase == PH_ARITH) begin
        arith_ctl <= op == ecs_op_add || op == ecs_op_sub;
      end
      if (phase == PH_LAST && arith_ctl && extend) begin
        operand <= operand >> 1;
      end
    end
  end

  // Shift counter: loaded at start, decremented each step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sctr <= 4'h0;
    end else if (state == ecs_idle && start) begin
      sctr <= shift_count;
    end else if (phase == PH_RESTORE && sctr != 4'h0
        && (state == ecs_step_one || state == ecs_step_two
        || state == ecs_step_three)) begin
      sctr <= sctr - 4'h1;
    end else if (phase == PH_LAST && extend && op == ecs_op_double
        && sctr != 4'h0) begin
      sctr <= sctr - 4'h1;
    end
  end

  // Accumulator and its stash
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc <= 16'h0;
      stash <= 16'h0;
    end else if (state == ecs_idle && start) begin
      stash <= acc;
      acc <= eff_addr;
    end else if (state == ecs_indirect && phase == PH_STORE) begin
      acc <= latch;
    end else if (state == ecs_step_one && phase == PH_RESTORE
        && op != ecs_op_io) begin
      acc <= stash;
    end else if (phase == PH_STORE && state != ecs_instr) begin
      if (op == ecs_op_io && state == ecs_step_two) begin
        if (func == FN_READ || func == FN_WRITE) begin
          acc <= latch;
        end else if (func == FN_SENSE_DEV || func == FN_SENSE_INT) begin
          acc <= latch;
        end
      end else if (op == ecs_op_add) begin
        acc <= acc + operand;
      end else if (op == ecs_op_sub) begin
        acc <= acc - operand;
      end else if (op == ecs_op_single || op == ecs_op_double) begin
        acc <= operand;
      end
    end
  end

  // Write back and store; a sense step read nothing, so writes nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_wr <= 1'b0;
      mem_wdata <= 16'h0;
    end else begin
      mem_wr <= 1'b0;
      if (phase == PH_STORE && state != ecs_idle && state != ecs_instr
          && !(state == ecs_step_two && op == ecs_op_io
          && is_sense(func))) begin
        mem_wr <= 1'b1;
        if (op == ecs_op_store) begin
          mem_wdata <= acc;
        end else if (state == ecs_step_three && func == FN_READ) begin
          mem_wdata <= io.in_bus;
        end else begin
          mem_wdata <= latch;
        end
      end
    end
  end

  // ***************************************************
  // I/O bus control
  // ***************************************************
  // Out-bus, control and data strobes, channel address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io.out_bus <= 16'h0;
      io.out_ctrl <= 1'b0;
      io.out_data <= 1'b0;
      io.in_sample <= 1'b0;
      io.car_load <= 16'h0;
      io.car_strobe <= 1'b0;
      channel_address_register <= 16'h0;
      func <= FN_DIAG;
    end else begin
      io.out_ctrl <= 1'b0;
      io.out_data <= 1'b0;
      io.in_sample <= 1'b0;
      io.car_strobe <= 1'b0;
      if (op == ecs_op_io && phase == PH_LATCH) begin
        if (state == ecs_step_one) begin
          io.out_bus <= latch;
          io.out_ctrl <= 1'b1;
          func <= latch[FUNC_MSB:FUNC_LSB];
        end else if (state == ecs_step_two) begin
          if (func == FN_INIT_READ || func == FN_INIT_WRITE) begin
            channel_address_register <= latch;
            io.car_load <= latch;
            io.car_strobe <= 1'b1;
          end else if (func == FN_CONTROL || func == FN_DIAG) begin
            io.out_bus <= latch;
            io.out_data <= 1'b1;
          end
        end else if (state == ecs_step_three && func == FN_WRITE) begin
          io.out_bus <= latch;
          io.out_data <= 1'b1;
        end
      end
      if (op == ecs_op_io && phase == PH_FIRST
          && ((state == ecs_step_two && (func == FN_SENSE_DEV
          || func == FN_SENSE_INT))
          || (state == ecs_step_three && func == FN_READ))) begin
        io.in_sample <= 1'b1;
      end
    end
  end
endmodule : ecs_seq

// *** src/ecs_adapter.sv ***
`timescale 1ns/1ps
// I/O adapter end: decodes the control word and answers
module ecs_adapter (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] my_area,
  input wire logic [15:0] status_in,
  input wire logic [15:0] read_data,
  output logic selected,
  output logic diag_mode,
  output logic [4:0] int_level,
  output logic [2:0] cur_func,
  output logic [7:0] cur_mod,
  output logic [15:0] write_data,
  output logic write_valid,
  output logic [15:0] car_copy,
  ecs_io_if.adapter io
);
  import ecs_pkg::*;

  // Area and function decode on the control strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selected <= 1'b0;
      cur_func <= FN_DIAG;
      cur_mod <= 8'h0;
      diag_mode <= 1'b0;
    end else if (io.out_ctrl) begin
      selected <= io.out_bus[AREA_MSB:AREA_LSB] == my_area;
      cur_func <= io.out_bus[FUNC_MSB:FUNC_LSB];
      cur_mod <= io.out_bus[MOD_MSB:MOD_LSB];
      if (io.out_bus[AREA_MSB:AREA_LSB] == my_area
          && io.out_bus[FUNC_MSB:FUNC_LSB] == FN_DIAG) begin
        diag_mode <= io.out_bus[DIAG_BIT];
      end
    end
  end

  // Interrupt level: lowest priority while in diagnostic mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_level <= 5'h0;
    end else begin
      int_level <= diag_mode ? DIAG_LEVEL : my_area;
    end
  end

  // Answer sense and read, take write data, track channel address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io.in_bus <= 16'h0;
      io.in_valid <= 1'b0;
      write_data <= 16'h0;
      write_valid <= 1'b0;
      car_copy <= 16'h0;
    end else begin
      io.in_valid <= 1'b0;
      write_valid <= 1'b0;
      if (selected && io.in_sample) begin
        if (cur_func == FN_SENSE_DEV || cur_func == FN_SENSE_INT) begin
          io.in_bus <= status_in;
          io.in_valid <= 1'b1;
        end else if (cur_func == FN_READ) begin
          io.in_bus <= read_data;
          io.in_valid <= 1'b1;
        end
      end
      if (selected && io.out_data && cur_func == FN_WRITE) begin
        write_data <= io.out_bus;
        write_valid <= 1'b1;
      end
      if (selected && io.car_strobe) begin
        car_copy <= io.car_load;
      end
    end
  end
endmodule : ecs_adapter

// *** bench/ecs_io_asserts.sv ***
`timescale 1ns/1ps
// Watches the out-bus and in-bus between sequencer and adapter
module ecs_io_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] out_bus,
  input wire logic out_ctrl,
  input wire logic out_data,
  input wire logic in_sample,
  input wire logic [15:0] car_load,
  input wire logic car_strobe,
  input wire logic [15:0] in_bus,
  input wire logic in_valid
);
  logic [7:0] since_ctrl;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************
  // Cycles since the last control word
  // ****************************************
  // Saturates so that a long idle never wraps into the window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_ctrl <= 8'hff;
    end else if (out_ctrl) begin
      since_ctrl <= 8'h00;
    end else if (since_ctrl != 8'hff) begin
      since_ctrl <= since_ctrl + 8'h01;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  a_ctrl_once: assert property (out_ctrl |=> !out_ctrl [*7])
    else $error("control word strobed twice in one cycle");
  a_ctrl_alone: assert property (
    out_ctrl |-> !(out_data || car_strobe || in_sample))
    else $error("control word shares its cycle");
  a_bus_hold: assert property (
    $changed(out_bus) |-> (out_ctrl || out_data || car_strobe))
    else $error("out bus changed without a load");
  a_car_step_two: assert property (
    car_strobe |-> (since_ctrl >= 8'h02) && (since_ctrl < 8'h10))
    else $error("channel address loaded outside step two");
  a_data_in_step: assert property (
    out_data |-> (since_ctrl >= 8'h02) && (since_ctrl < 8'h18))
    else $error("data word outside steps two and three");
  a_sample_in_step: assert property (
    in_sample |-> (since_ctrl >= 8'h02) && (since_ctrl < 8'h18))
    else $error("input sample outside steps two and three");
  a_sample_answered: assert property (
    in_sample |-> ##[0:4] in_valid)
    else $error("input sample not answered");
  a_valid_pulse: assert property ($rose(in_valid) |=> !in_valid)
    else $error("input valid longer than one cycle");

  // Main scenarios reached
  c_ctrl: cover property (out_ctrl);
  c_car: cover property (car_strobe);
  c_valid: cover property (in_valid);
  c_data: cover property (out_data);
endmodule : ecs_io_asserts

// *** bench/testbench.sv ***
`timescale 1ns/1ps
// Sequencer and adapter joined through the I/O interface
module testbench;
  import ecs_pkg::*;
  logic clk, rst, start, busy, done, mem_rd, mem_wr;
  ecs_op_t op_class;
  logic [15:0] instr_word, eff_addr, acc, channel_address_register, mem_addr, mem_wdata, mem_rdata;
  logic [3:0] shift_count;
  logic [2:0] phase, cur_func;
  logic [4:0] my_area, int_level;
  logic [15:0] status_in, read_data, write_data, car_copy, wseen;
  logic selected, diag_mode, write_valid;
  logic [7:0] cur_mod;
  logic [15:0] mem [16];
  int error_cnt, checks, wr_cnt, cyc, base;
  int tick = 0;
  ecs_op_t ops [11] = '{ecs_op_wait, ecs_op_shift, ecs_op_ldstat,
    ecs_op_branch, ecs_op_ldx_noreg, ecs_op_single, ecs_op_add,
    ecs_op_double, ecs_op_sub, ecs_op_store, ecs_op_cmp};
  int nwr [11] = '{0, 0, 0, 0, 0, 1, 1, 2, 1, 1, 1};

  ecs_io_if ecs_io_if_i (.clk(clk), .rst(rst));
  ecs_seq ecs_seq_i (.clk(clk), .rst(rst), .start(start),
    .op_class(op_class), .instr_word(instr_word), .eff_addr(eff_addr),
    .shift_count(shift_count), .busy(busy), .done(done), .acc(acc),
    .channel_address_register(channel_address_register), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .phase(phase),
    .io(ecs_io_if_i));
  ecs_adapter ecs_adapter_i (.clk(clk), .rst(rst), .my_area(my_area),
    .status_in(status_in), .read_data(read_data), .selected(selected),
    .diag_mode(diag_mode), .int_level(int_level), .cur_func(cur_func),
    .cur_mod(cur_mod), .write_data(write_data),
    .write_valid(write_valid), .car_copy(car_copy), .io(ecs_io_if_i));
  ecs_io_asserts ecs_io_asserts_i (.clk(clk), .rst(rst),
    .out_bus(ecs_io_if_i.out_bus), .out_ctrl(ecs_io_if_i.out_ctrl),
    .out_data(ecs_io_if_i.out_data), .in_sample(ecs_io_if_i.in_sample),
    .car_load(ecs_io_if_i.car_load), .car_strobe(ecs_io_if_i.car_strobe),
    .in_bus(ecs_io_if_i.in_bus), .in_valid(ecs_io_if_i.in_valid));

  // ****************************************
  // Clock, storage model and monitors
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Storage answers in the same cycle as the read
  assign mem_rdata = mem[mem_addr[3:0]];

  // Write-back into storage, count of writes, adapter output capture
  always @(posedge clk) begin
    if (mem_wr === 1'b1) begin
      mem[mem_addr[3:0]] <= mem_wdata;
      wr_cnt++;
    end
    if (write_valid === 1'b1) begin
      wseen <= write_data;
    end
  end

  // Cuts a hang short
  always @(posedge clk) begin
    tick <= tick + 1;
    if (tick == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One instruction: start pulse, then wait for done
  task automatic run(input ecs_op_t op, input logic [15:0] iw,
                     input logic [15:0] ea);
    @(posedge clk);
    start <= 1'b1;
    op_class <= op;
    instr_word <= iw;
    eff_addr <= ea;
    wr_cnt = 0;
    @(posedge clk);
    start <= 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 200) begin
      @(posedge clk);
      cyc++;
    end
    if (done !== 1'b1) begin
      error_cnt++;
      $display("unexpected done expected 1 seen 0");
    end
    check("busy", 16'(busy), 16'h0000);
    check("phase", {13'h0, phase}, {13'h0, PH_FIRST});
    @(posedge clk);
  endtask : run

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst = 1'b1;
    start = 1'b0;
    op_class = ecs_op_wait;
    instr_word = 16'h0000;
    eff_addr = 16'h0000;
    shift_count = 4'h0;
    my_area = 5'h03;
    status_in = 16'h0000;
    read_data = 16'h0000;
    wseen = 16'h0000;
    error_cnt = 0;
    checks = 0;
    wr_cnt = 0;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'h0000;
    end
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Step counts per opcode class
    for (int k = 0; k < 11; k++) begin
      run(ops[k], 16'h0000, 16'h0008);
      check("writes", 16'(wr_cnt), 16'(nwr[k]));
      check("cycles", 16'((cyc + 4) / 8), 16'(nwr[k] + 1));
    end
    $display("test step counts finished");
    // Last phase stretched by a nonzero add operand
    run(ecs_op_add, 16'h0000, 16'h0008);
    base = cyc;
    mem[8] = 16'h0007;
    run(ecs_op_add, 16'h0000, 16'h0008);
    check("extend", 16'(cyc > base), 16'h0001);
    // Double word with a nonzero shift counter stretches too
    shift_count <= 4'h3;
    run(ecs_op_double, 16'h0000, 16'h0008);
    check("shift extend", 16'(cyc > 26), 16'h0001);
    shift_count <= 4'h0;
    $display("test extension finished");
    // Indirect cycle before the single step
    mem[4] = 16'h0009;
    run(ecs_op_single, 16'h0120, 16'h0004);
    check("ind writes", 16'(wr_cnt), 16'h0002);
    check("ind word", mem[4], 16'h0009);
    $display("test indirect finished");
    // Load a word, then store it elsewhere from the restored accumulator
    mem[6] = 16'h4321;
    run(ecs_op_single, 16'h0000, 16'h0006);
    check("load", acc, 16'h4321);
    run(ecs_op_store, 16'h0000, 16'h0005);
    check("store", mem[5], 16'h4321);
    $display("test load store finished");
    // Every function code of the execute I/O instruction
    for (int f = 0; f < 8; f++) begin
      mem[2] = 16'h000c;
      mem[3] = {8'h80, f[2:0], 5'h03};
      mem[12] = 16'hbee0 + 16'(f);
      status_in <= 16'h5a50 + 16'(f);
      read_data <= 16'h1230 + 16'(f);
      run(ecs_op_io, 16'h0000, 16'h0002);
      check("func", {13'h0, cur_func}, 16'(f));
      check("mod", {8'h0, cur_mod}, 16'h0080);
      check("io cycles", 16'((cyc + 4) / 8), 16'((f == 1 || f == 2) ? 4 : 3));
      case (f)
        0: check("diag", 16'(diag_mode), 16'h0001);
        1: check("wdata", wseen, 16'hbee1);
        2: check("rdata", mem[12], 16'h1232);
        3, 7: check("status", acc, 16'h5a50 + 16'(f));
        5, 6: check("car", car_copy, 16'h000c);
        default: check("sel", 16'(selected), 16'h0001);
      endcase
    end
    check("seq car", channel_address_register, 16'h000c);
    check("diag level", {11'h0, int_level}, {11'h0, DIAG_LEVEL});
    // Diagnostic mode cleared, then another area addressed
    mem[3] = 16'h0003;
    run(ecs_op_io, 16'h0000, 16'h0002);
    check("diag off", 16'(diag_mode), 16'h0000);
    check("own level", {11'h0, int_level}, 16'h0003);
    mem[3] = {8'h00, FN_CONTROL, 5'h04};
    run(ecs_op_io, 16'h0000, 16'h0002);
    check("other area", 16'(selected), 16'h0000);
    $display("test io functions finished");
    print_verdict();
  end
endmodule : testbench
